/* File: rtl/plut_cfg.svh */
/*
 Constants of the pixel table block: register addresses, field positions,
 reset values and table geometry.
 Assumes it is included by bare name from the package and the design files.
*/
`ifndef PLUT_CFG_SVH
`define PLUT_CFG_SVH

// Register byte addresses on the APB
`define PLUT_CTRL_ADDR   32'hF100_0240
`define PLUT_MEM_ADDR    32'hF100_0244
`define PLUT_CAP_ADDR    32'hF100_0248
`define PLUT_WIN_ADDR    32'hF100_0300
`define PLUT_WINFO_ADDR  32'hF100_0304

// Field positions (word bit 31 is the first bit of the register)
`define PLUT_PRES_BIT    31
`define PLUT_EN_BIT      25
`define PLUT_IDX_LSB     0
`define PLUT_IDX_W       6
`define PLUT_WREN_BIT    26
`define PLUT_WIDX_LSB    16
`define PLUT_WIDX_W      8
`define PLUT_OFS_LSB     0
`define PLUT_OFS_W       16
`define PLUT_BPV_LSB     24
`define PLUT_BPV_W       5
`define PLUT_CNT_LSB     16
`define PLUT_CNT_W       8
`define PLUT_MAX_LSB     0
`define PLUT_MAX_W       16
`define PLUT_CTRL_RSVD   32'h7DFF_FFC0

// Reset values
`define PLUT_EN_RST      1'h0
`define PLUT_IDX_RST     6'h00
`define PLUT_WREN_RST    1'h0
`define PLUT_WIDX_RST    8'h00
`define PLUT_OFS_RST     16'h0000

// Table geometry
`define PLUT_GRAY_BITS   10
`define PLUT_ENTRY_BITS  12
`define PLUT_ENTRY_BYTES ((`PLUT_ENTRY_BITS + 7) / 8)
`define PLUT_TABLE_COUNT 2
`define PLUT_SEL_W       1
`define PLUT_TABLE_BYTES (`PLUT_ENTRY_BYTES << `PLUT_GRAY_BITS)
`define PLUT_TAB_AW      11
`define PLUT_MEM_AW      12
`define PLUT_MEM_BYTES   (`PLUT_TABLE_COUNT * `PLUT_TABLE_BYTES)
`define PLUT_WINDOW_BYTES 4
`define PLUT_LANES       4

`endif

/* File: rtl/plut_pkg.sv */
/*
 Types of the pixel table block: register decode and state records.
 Assumes plut_cfg.svh is found on the include path.
*/
`include "plut_cfg.svh"

package plut_pkg;

    // Register selected by an APB address
    typedef enum logic [2:0] {
        PLUT_R_CTRL,
        PLUT_R_MEM,
        PLUT_R_CAP,
        PLUT_R_WIN,
        PLUT_R_WINFO,
        PLUT_R_NONE
    } plut_reg_e;

    // All state of the control block
    typedef struct packed {
        logic                          en;
        logic [`PLUT_IDX_W-1:0]        idx;
        logic                          wren;
        logic [`PLUT_WIDX_W-1:0]       widx;
        logic [`PLUT_OFS_W-1:0]        ofs;
        logic                          gamma;
        logic [31:0]                   prdata;
        logic                          s1_valid;
        logic                          s1_map;
        logic [`PLUT_GRAY_BITS-1:0]    s1_raw;
        logic                          out_valid;
        logic [`PLUT_ENTRY_BITS-1:0]   out_data;
    } plut_state_s;

    // State of the table memory read port
    typedef struct packed {
        logic [`PLUT_ENTRY_BYTES*8-1:0] rd_data;
    } plut_mem_s;

endpackage

/* File: rtl/plut_table_mem.sv */
/*
 Byte-wide table storage with one write lane per APB byte and one
 registered entry read for the pixel path.
 Assumes both ports run on pclk; entries are stored low byte first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "plut_cfg.svh"

module plut_table_mem
    import plut_pkg::*;
(
    // Clock and reset
    input  wire logic                                    pclk,
    input  wire logic                                    presetn,
    // Byte write lanes
    input  wire logic [`PLUT_LANES-1:0]                  wr_en,
    input  wire logic [`PLUT_LANES-1:0][`PLUT_MEM_AW-1:0] wr_addr,
    input  wire logic [`PLUT_LANES-1:0][7:0]             wr_byte,
    // Entry read
    input  wire logic                                    rd_en,
    input  wire logic [`PLUT_MEM_AW-2:0]                 rd_entry,
    output logic      [`PLUT_ENTRY_BYTES*8-1:0]          rd_data
);

    logic [7:0]  mem [`PLUT_MEM_BYTES];
    plut_mem_s   st_q;
    plut_mem_s   st_d;
    logic [`PLUT_ENTRY_BYTES*8-1:0] rd_bytes;

    // Gather the bytes of one entry
    genvar b;
    for (b = 0; b < `PLUT_ENTRY_BYTES; b++) begin : g_byte
        assign rd_bytes[8*b +: 8] = mem[rd_entry * `PLUT_ENTRY_BYTES + b];
    end

    // Contents are not reset; software loads them before use
    always_ff @(posedge pclk) begin
        for (int l = 0; l < `PLUT_LANES; l++) begin
            if (wr_en[l]) begin
                mem[wr_addr[l]] <= wr_byte[l];
            end
        end
    end

    // Read register holds the last entry fetched
    always_comb begin
        st_d = st_q;
        if (rd_en) begin
            st_d.rd_data = rd_bytes;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd_data;

endmodule // plut_table_mem

`default_nettype wire

/* File: rtl/plut_ctrl.sv */
/*
 Pixel look-up table control: APB registers, chunked table loading through
 a one-word bulk window, pixel mapping and the hand-off with gamma.
 Assumes pixels and gamma pulses come from logic on pclk.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "plut_cfg.svh"

module plut_ctrl
    import plut_pkg::*;
(
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic                              pready,
    output logic      [31:0]                  prdata,
    output logic                              pslverr,
    // Gamma function requests
    input  wire logic                         gamma_on,
    input  wire logic                         gamma_off,
    // Pixel stream
    input  wire logic                         pix_valid_in,
    input  wire logic [`PLUT_GRAY_BITS-1:0]   pix_gray_in,
    output logic                              pix_valid_out,
    output logic      [`PLUT_ENTRY_BITS-1:0]  pix_data_out,
    // Status
    output logic                              table_enable,
    output logic      [`PLUT_IDX_W-1:0]       active_table_index,
    output logic                              gamma_active
);

    localparam int POS_W = `PLUT_OFS_W + 1;
    localparam int PAD_W = `PLUT_ENTRY_BITS - `PLUT_GRAY_BITS;

    plut_state_s st_q;
    plut_state_s st_d;

    logic        setup;
    logic        acc;
    plut_reg_e   acc_reg;
    logic        win_wr;
    logic        widx_ok;
    logic [31:0] rd_word;

    logic [`PLUT_LANES-1:0]                   lane_we;
    logic [`PLUT_LANES-1:0][`PLUT_MEM_AW-1:0] lane_addr;
    logic [`PLUT_LANES-1:0][7:0]              lane_byte;
    logic [`PLUT_LANES-1:0][POS_W-1:0]        lane_pos;

    logic [`PLUT_ENTRY_BYTES*8-1:0] mem_rd;
    logic [`PLUT_ENTRY_BITS-1:0]    mem_entry;
    logic [`PLUT_MEM_AW-2:0]        rd_entry;
    logic                           map_now;

    // Address decode, shared by the read mux and the write path
    function automatic plut_reg_e plut_decode(input logic [31:0] a);
        case (a)
            `PLUT_CTRL_ADDR:  plut_decode = PLUT_R_CTRL;
            `PLUT_MEM_ADDR:   plut_decode = PLUT_R_MEM;
            `PLUT_CAP_ADDR:   plut_decode = PLUT_R_CAP;
            `PLUT_WIN_ADDR:   plut_decode = PLUT_R_WIN;
            `PLUT_WINFO_ADDR: plut_decode = PLUT_R_WINFO;
            default:          plut_decode = PLUT_R_NONE;
        endcase
    endfunction

    // Bytes in one chunk: the number of strobed lanes
    function automatic logic [POS_W-1:0] chunk_len(input logic [3:0] s);
        logic [POS_W-1:0] n;
        n = '0;
        for (int i = 0; i < `PLUT_LANES; i++) begin
            n = n + POS_W'(s[i]);
        end
        return n;
    endfunction

    // APB phases; no wait states, so pready is always high
    assign setup   = psel && !penable;
    assign acc     = psel && penable;
    assign acc_reg = plut_decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = acc && (acc_reg == PLUT_R_NONE);
    assign win_wr  = acc && pwrite && (acc_reg == PLUT_R_WIN);

    // A load aimed at a table that does not exist writes nothing
    assign widx_ok = st_q.widx < `PLUT_WIDX_W'(`PLUT_TABLE_COUNT);

    // One write lane per byte; lane g lands at offset plus g
    genvar g;
    for (g = 0; g < `PLUT_LANES; g++) begin : g_lane
        assign lane_pos[g]  = {1'b0, st_q.ofs} + POS_W'(g);
        assign lane_we[g]   = win_wr && st_q.wren && pstrb[g] && widx_ok
                              && (lane_pos[g] < POS_W'(`PLUT_TABLE_BYTES));
        assign lane_addr[g] = {st_q.widx[`PLUT_SEL_W-1:0],
                               lane_pos[g][`PLUT_TAB_AW-1:0]};
        assign lane_byte[g] = pwdata[8*g +: 8];
    end

    // Entry index: table select above the gray value, so each gray
    // value owns exactly one entry of the selected table
    assign rd_entry  = {st_q.idx[`PLUT_SEL_W-1:0], pix_gray_in};
    assign map_now   = st_q.en && (st_q.idx < `PLUT_IDX_W'(`PLUT_TABLE_COUNT));
    assign mem_entry = mem_rd[`PLUT_ENTRY_BITS-1:0];

    plut_table_mem u_mem (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_en    (lane_we),
        .wr_addr  (lane_addr),
        .wr_byte  (lane_byte),
        .rd_en    (pix_valid_in),
        .rd_entry (rd_entry),
        .rd_data  (mem_rd)
    );

    // Read mux; fields not named here stay zero
    always_comb begin
        rd_word = '0;
        case (acc_reg)
            PLUT_R_CTRL: begin
                rd_word[`PLUT_PRES_BIT] = 1'b1;
                rd_word[`PLUT_EN_BIT] = st_q.en;
                rd_word[`PLUT_IDX_LSB +: `PLUT_IDX_W] = st_q.idx;
            end
            PLUT_R_MEM: begin
                rd_word[`PLUT_PRES_BIT] = 1'b1;
                rd_word[`PLUT_WREN_BIT] = st_q.wren;
                rd_word[`PLUT_WIDX_LSB +: `PLUT_WIDX_W] = st_q.widx;
                rd_word[`PLUT_OFS_LSB +: `PLUT_OFS_W] = st_q.ofs;
            end
            PLUT_R_CAP: begin
                rd_word[`PLUT_PRES_BIT] = 1'b1;
                rd_word[`PLUT_BPV_LSB +: `PLUT_BPV_W] =
                    `PLUT_BPV_W'(`PLUT_ENTRY_BITS);
                rd_word[`PLUT_CNT_LSB +: `PLUT_CNT_W] =
                    `PLUT_CNT_W'(`PLUT_TABLE_COUNT);
                rd_word[`PLUT_MAX_LSB +: `PLUT_MAX_W] =
                    `PLUT_MAX_W'(`PLUT_TABLE_BYTES);
            end
            PLUT_R_WINFO: begin
                rd_word[`PLUT_OFS_LSB +: `PLUT_OFS_W] =
                    `PLUT_OFS_W'(`PLUT_WINDOW_BYTES);
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Next state: registers, gamma hand-off and the pixel pipeline
    always_comb begin
        st_d = st_q;
        // Read data is captured in setup so it comes from a flop
        if (setup) begin
            st_d.prdata = rd_word;
        end
        if (acc && pwrite) begin
            case (acc_reg)
                PLUT_R_CTRL: begin
                    st_d.en    = pwdata[`PLUT_EN_BIT];
                    st_d.idx   = pwdata[`PLUT_IDX_LSB +: `PLUT_IDX_W];
                    st_d.gamma = 1'b0;
                end
                PLUT_R_MEM: begin
                    st_d.wren = pwdata[`PLUT_WREN_BIT];
                    st_d.widx = pwdata[`PLUT_WIDX_LSB +: `PLUT_WIDX_W];
                    st_d.ofs  = pwdata[`PLUT_OFS_LSB +: `PLUT_OFS_W];
                end
                PLUT_R_WIN: begin
                    // Chunks while loading is off are dropped whole
                    if (st_q.wren) begin
                        st_d.ofs = st_q.ofs +
                                   `PLUT_OFS_W'(chunk_len(pstrb));
                    end
                end
                default: begin
                    st_d.ofs = st_q.ofs; // Read-only or unmapped: no effect
                end
            endcase
        end
        // Gamma rides on the table hardware, so it switches the table;
        // gamma on is applied last so it wins a same-cycle write
        if (gamma_off) begin
            st_d.en    = 1'b0;
            st_d.gamma = 1'b0;
        end
        if (gamma_on) begin
            st_d.en    = 1'b1;
            st_d.gamma = 1'b1;
        end
        // Stage 1: memory fetch under way, remember the raw value
        st_d.s1_valid = pix_valid_in;
        if (pix_valid_in) begin
            st_d.s1_map = map_now;
            st_d.s1_raw = pix_gray_in;
        end
        // Stage 2: mapped entry, or the raw value left aligned
        st_d.out_valid = st_q.s1_valid;
        if (st_q.s1_valid) begin
            st_d.out_data = st_q.s1_map ? mem_entry
                          : {st_q.s1_raw, {PAD_W{1'b0}}};
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= '0;
            st_q.en    <= `PLUT_EN_RST;
            st_q.idx   <= `PLUT_IDX_RST;
            st_q.wren  <= `PLUT_WREN_RST;
            st_q.widx  <= `PLUT_WIDX_RST;
            st_q.ofs   <= `PLUT_OFS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs, all straight from the state register
    assign prdata             = st_q.prdata;
    assign pix_valid_out      = st_q.out_valid;
    assign pix_data_out       = st_q.out_data;
    assign table_enable       = st_q.en;
    assign active_table_index = st_q.idx;
    assign gamma_active       = st_q.gamma;

    // Checks on the logic above
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_ctrl_wr;
        acc && pwrite && (acc_reg == PLUT_R_CTRL) && !gamma_on && !gamma_off;
    endsequence

    sequence s_chunk;
        win_wr && st_q.wren;
    endsequence

    sequence s_pix_raw;
        pix_valid_in && !map_now;
    endsequence

    property p_ctrl_takes_index;
        s_ctrl_wr |=> (active_table_index == $past(pwdata[5:0]))
                      && (table_enable == $past(pwdata[`PLUT_EN_BIT]));
    endproperty
    a_ctrl_takes_index: assert property (p_ctrl_takes_index)
        else $error("control write not applied");

    property p_bypass;
        s_pix_raw ##1 1'b1 |=> pix_valid_out
            && (pix_data_out[`PLUT_ENTRY_BITS-1 -: `PLUT_GRAY_BITS]
                == $past(pix_gray_in, 2));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("unmapped pixel altered");

    property p_mapped;
        pix_valid_in && map_now |=> ##1 pix_valid_out
            && (pix_data_out == $past(mem_entry));
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped pixel not from table");

    property p_cap_read;
        setup && (acc_reg == PLUT_R_CAP) |=>
            (prdata[`PLUT_CNT_LSB +: `PLUT_CNT_W] == `PLUT_TABLE_COUNT)
            && (prdata[`PLUT_MAX_LSB +: `PLUT_MAX_W] == `PLUT_TABLE_BYTES)
            && (prdata[`PLUT_BPV_LSB +: `PLUT_BPV_W] == `PLUT_ENTRY_BITS);
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("capability fields wrong");

    // Reported size must equal whole bytes per entry times one entry per gray value
    property p_geometry;
        setup && (acc_reg == PLUT_R_CAP) |=> (prdata[`PLUT_MAX_LSB +: `PLUT_MAX_W]
            == (((prdata[`PLUT_BPV_LSB +: `PLUT_BPV_W] + 7) / 8) << `PLUT_GRAY_BITS));
    endproperty
    a_geometry: assert property (p_geometry)
        else $error("entry or table size inconsistent");

    property p_offset_advance;
        s_chunk and !(acc && pwrite && acc_reg == PLUT_R_MEM) |=>
            st_q.ofs == $past(st_q.ofs) + `PLUT_OFS_W'(chunk_len($past(pstrb)));
    endproperty
    a_offset_advance: assert property (p_offset_advance)
        else $error("offset did not advance by chunk");

    sequence s_mem_wr;
        acc && pwrite && (acc_reg == PLUT_R_MEM);
    endsequence

    property p_mem_ctrl_write;
        s_mem_wr |=> (st_q.wren == $past(pwdata[`PLUT_WREN_BIT]))
            && (st_q.widx == $past(pwdata[`PLUT_WIDX_LSB +: `PLUT_WIDX_W]))
            && (st_q.ofs == $past(pwdata[`PLUT_OFS_LSB +: `PLUT_OFS_W]));
    endproperty
    a_mem_ctrl_write: assert property (p_mem_ctrl_write)
        else $error("memory access fields not stored");

    property p_gamma_on;
        gamma_on |=> table_enable && gamma_active;
    endproperty
    a_gamma_on: assert property (p_gamma_on)
        else $error("gamma on did not enable table");

    property p_table_write_kills_gamma;
        s_ctrl_wr |=> !gamma_active;
    endproperty
    a_table_write_kills_gamma: assert property (p_table_write_kills_gamma)
        else $error("table write left gamma on");

    property p_present_and_reserved;
        setup && (acc_reg == PLUT_R_CTRL) |=> prdata[`PLUT_PRES_BIT]
            && ((prdata & `PLUT_CTRL_RSVD) == 32'h0000_0000);
    endproperty
    a_present_and_reserved: assert property (p_present_and_reserved)
        else $error("control reserved bits or presence wrong");

endmodule // plut_ctrl

`default_nettype wire

/* File: verif/plut_ctrl_tb.sv */
/*
 Self-checking bench of plut_ctrl: register map over APB, chunked table
 loading, pixel mapping and the gamma hand-off, random data from a seed.
 Assumes plut_cfg.svh on the include path and plut_pkg compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "plut_cfg.svh"

module plut_ctrl_tb
    import plut_pkg::*;
;
    localparam int TB = `PLUT_TABLE_BYTES;

    logic                        pclk;
    logic                        presetn;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [31:0]                 paddr;
    logic [31:0]                 pwdata;
    logic [3:0]                  pstrb;
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic                        gamma_on;
    logic                        gamma_off;
    logic                        pix_valid_in;
    logic [`PLUT_GRAY_BITS-1:0]  pix_gray_in;
    logic                        pix_valid_out;
    logic [`PLUT_ENTRY_BITS-1:0] pix_data_out;
    logic                        table_enable;
    logic [`PLUT_IDX_W-1:0]      active_table_index;
    logic                        gamma_active;
    logic [7:0]                  tmem [2][TB];
    logic [11:0]                 exp_q [$];
    logic [31:0]                 rd;
    logic                        err;
    logic                        tb_en;
    logic [5:0]                  tb_idx;
    int                          bad_count;
    int                          n_tests;
    int                          k;

    plut_ctrl plut_ctrl_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .gamma_on, .gamma_off, .pix_valid_in,
        .pix_gray_in, .pix_valid_out, .pix_data_out, .table_enable,
        .active_table_index, .gamma_active
    );

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd, e);
    endtask

    // Control write; the bench mirrors enable and index for the pixel model
    task automatic ctl(input logic en, input logic [5:0] idx);
        apb(1'b1, `PLUT_CTRL_ADDR, {6'h00, en, 19'h0_0000, idx}, 4'hF);
        tb_en = en;
        tb_idx = idx;
    endtask

    // Expected pixel: two bytes per 12-bit entry, low byte first
    function automatic logic [11:0] map_pix(input logic [9:0] g);
        if (tb_en && tb_idx < 2)
            return {tmem[tb_idx[0]][2*g+1][3:0], tmem[tb_idx[0]][2*g]};
        return {g, 2'b00};
    endfunction

    // Whole table in chunks; half-word chunks at both ends test the step
    task automatic load(input int t);
        int         o;
        int         i;
        logic [3:0] s;
        logic [31:0] d;
        apb(1'b1, `PLUT_MEM_ADDR, 32'h0400_0000 | (t << 16), 4'hF);
        o = 0;
        while (o < TB) begin
            s = (o == 0 || TB - o < 4) ? 4'h3 : 4'hF;
            d = $urandom;
            for (i = 0; i < 4; i++)
                if (s[i]) tmem[t][o+i] = d[8*i+:8];
            apb(1'b1, `PLUT_WIN_ADDR, d, s);
            o += (s == 4'h3) ? 2 : 4;
            if (o == 2)
                rdchk(`PLUT_MEM_ADDR, 32'h8400_0002 | (t << 16));
        end
        rdchk(`PLUT_MEM_ADDR, 32'h8400_0800 | (t << 16));
        apb(1'b1, `PLUT_MEM_ADDR, 32'h0000_0000, 4'hF);
    endtask

    // Back-to-back pixels, extreme gray values first
    task automatic pix_run(input int cnt);
        int         i;
        logic [9:0] g;
        for (i = 0; i < cnt; i++) begin
            @(posedge pclk);
            g = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
            pix_valid_in <= 1'b1;
            pix_gray_in <= g;
            exp_q.push_back(map_pix(g));
        end
        @(posedge pclk);
        pix_valid_in <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(exp_q.size(), 0);
    endtask

    // Single-cycle gamma pulse, then the two status levels
    task automatic gpulse(input logic on, input logic [1:0] e);
        @(posedge pclk);
        gamma_on <= on;
        gamma_off <= ~on;
        @(posedge pclk);
        gamma_on <= 1'b0;
        gamma_off <= 1'b0;
        @(posedge pclk);
        #1;
        chk({table_enable, gamma_active}, e);
    endtask

    // Output monitor; pixels come out in order, one per input
    always @(posedge pclk) begin
        if (pix_valid_out === 1'b1) begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk(pix_data_out, exp_q.pop_front());
        end
    end

    // Watchdog, about six times the roughly 3.4k cycles the sequence needs
    initial begin
        #200_000;
        bad_count++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h3b80fee9));
        {presetn, psel, penable, pwrite, gamma_on, gamma_off, pix_valid_in} = '0;
        {paddr, pwdata, pstrb, pix_gray_in} = '0;
        {tb_en, tb_idx, bad_count, n_tests} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk({table_enable, gamma_active, active_table_index}, 0);
        // Register map, read-only and reserved bits
        rdchk(`PLUT_CTRL_ADDR, 32'h8000_0000);
        rdchk(`PLUT_MEM_ADDR, 32'h8000_0000);
        apb(1'b1, `PLUT_CAP_ADDR, 32'h0000_0000, 4'hF);
        rdchk(`PLUT_CAP_ADDR, 32'h8C02_0800);
        rdchk(`PLUT_WINFO_ADDR, 32'h0000_0004);
        rdchk(`PLUT_WIN_ADDR, 32'h0000_0000);
        chk(err, 0);
        rdchk(32'hF100_0250, 32'h0000_0000);
        chk(err, 1);
        apb(1'b1, `PLUT_CTRL_ADDR, 32'hFFFF_FFFF, 4'hF);
        rdchk(`PLUT_CTRL_ADDR, 32'h8200_003F);
        apb(1'b1, `PLUT_MEM_ADDR, 32'hFFFF_FFFF, 4'hF);
        rdchk(`PLUT_MEM_ADDR, 32'h84FF_FFFF);
        ctl(1'b0, 6'h00);
        // Table loading and refused chunks
        load(0);
        load(1);
        apb(1'b1, `PLUT_WIN_ADDR, $urandom, 4'hF);
        rdchk(`PLUT_MEM_ADDR, 32'h8000_0000);
        apb(1'b1, `PLUT_MEM_ADDR, 32'h0402_0000, 4'hF);
        apb(1'b1, `PLUT_WIN_ADDR, $urandom, 4'hF);
        rdchk(`PLUT_MEM_ADDR, 32'h8402_0004);
        apb(1'b1, `PLUT_MEM_ADDR, 32'h0000_0000, 4'hF);
        // Enable and index combinations: off, table 0, table 1, beyond count
        for (k = 0; k < 4; k++) begin
            ctl(k > 0, (k == 0) ? 6'h01 : 6'(k - 1));
            #1;
            chk({table_enable, active_table_index}, {tb_en, tb_idx});
            pix_run(40);
        end
        // Gamma and user table exclusion
        ctl(1'b0, 6'h00);
        gpulse(1'b1, 2'b11);
        rdchk(`PLUT_CTRL_ADDR, 32'h8200_0000);
        ctl(1'b1, 6'h00);
        #1;
        chk({table_enable, gamma_active}, 2'b10);
        gpulse(1'b1, 2'b11);
        ctl(1'b0, 6'h00);
        #1;
        chk({table_enable, gamma_active}, 2'b00);
        gpulse(1'b1, 2'b11);
        gpulse(1'b0, 2'b00);
        complete_run();
    end
endmodule // plut_ctrl_tb

`default_nettype wire
